// >>> core/amcd_core.sv
/*
 * Accelerometer vector-magnitude change detector: threshold, debounce and
 * reference registers, reference loading and event flag.
 * Assumes byte register accesses arrive as one-cycle strobes synchronous to
 * MCLK_I, one axis triple per output sample marked by SAMPLE_VALID_I, and a
 * one-cycle SRC_READ_I pulse when the host reads the interrupt source.
 * Samples arrive already scaled to the selected full-scale range.
 */
`timescale 1ns/1ps
`include "amcd_defines.svh"

// Summary of operation
// - Clear mode 0: below threshold decrements counter
// - Clear mode 1: below threshold clears counter
// - Threshold 13 bits: high[4:0], low[7:0]
// - Threshold step equals one output count
// - 8-bit count, one step per sample
// - Hybrid mode halves debounce sample rate
// - Signed 14-bit references per axis, split bytes
// - Programmed references used only when init-source set
// - Event when distance exceeds threshold past count
// - Load references at enable, registers or sample
// - Latch holds flag until source read
// - Init-source plus hold: writes update live reference
module amcd_core #(
   parameter int DATA_W = `AMCD_DATA_WIDTH,
   parameter int THS_W  = `AMCD_THS_WIDTH,
   parameter int CNT_W  = `AMCD_CNT_WIDTH
) (
   input  wire logic                     MCLK_I,
   input  wire logic                     SYS_RST_I,
   input  wire logic [7:0]               REG_ADDR_I,
   input  wire logic [7:0]               REG_WDATA_I,
   input  wire logic                     REG_WR_I,
   input  wire logic                     REG_RD_I,
   input  wire logic                     ENABLE_I,
   input  wire logic                     LATCH_EN_I,
   input  wire logic                     INIT_SRC_I,
   input  wire logic                     REF_HOLD_I,
   input  wire logic                     HYBRID_I,
   input  wire logic                     SRC_READ_I,
   input  wire logic                     SAMPLE_VALID_I,
   input  wire amcd_pkg::amcd_sample_t   SAMPLE_X_I,
   input  wire amcd_pkg::amcd_sample_t   SAMPLE_Y_I,
   input  wire amcd_pkg::amcd_sample_t   SAMPLE_Z_I,
   output logic [7:0]                    REG_RDATA_O,
   output logic                          EVENT_O,
   output logic                          ACTIVE_O
);
   import amcd_pkg::*;

   // Elaboration check: byte layout fixes these widths
   if (DATA_W != `AMCD_DATA_WIDTH || THS_W != `AMCD_THS_WIDTH || CNT_W != `AMCD_CNT_WIDTH) begin : g_chk
      $error("amcd_core: widths must match the byte register layout");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file

   logic [7:0]             ths_high_reg;
   logic [7:0]             ths_low_reg;
   logic [CNT_W-1:0]       db_count_reg;
   logic [7:0]             ref_x_high_reg;
   logic [7:0]             ref_x_low_reg;
   logic [7:0]             ref_y_high_reg;
   logic [7:0]             ref_y_low_reg;
   logic [7:0]             ref_z_high_reg;
   logic [7:0]             ref_z_low_reg;
   logic [THS_W-1:0]       threshold;
   logic                   clear_mode;
   amcd_sample_t           init_x;
   amcd_sample_t           init_y;
   amcd_sample_t           init_z;

   // Byte writes; unused high bits are kept as written since they read back R/W
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         ths_high_reg   <= `AMCD_REG_RESET;
         ths_low_reg    <= `AMCD_REG_RESET;
         db_count_reg   <= `AMCD_REG_RESET;
         ref_x_high_reg <= `AMCD_REG_RESET;
         ref_x_low_reg  <= `AMCD_REG_RESET;
         ref_y_high_reg <= `AMCD_REG_RESET;
         ref_y_low_reg  <= `AMCD_REG_RESET;
         ref_z_high_reg <= `AMCD_REG_RESET;
         ref_z_low_reg  <= `AMCD_REG_RESET;
      end else if (REG_WR_I) begin
         case (REG_ADDR_I)
            `AMCD_ADDR_THS_HIGH:   ths_high_reg   <= REG_WDATA_I;
            `AMCD_ADDR_THS_LOW:    ths_low_reg    <= REG_WDATA_I;
            `AMCD_ADDR_DB_COUNT:   db_count_reg   <= REG_WDATA_I;
            `AMCD_ADDR_REF_X_HIGH: ref_x_high_reg <= REG_WDATA_I;
            `AMCD_ADDR_REF_X_LOW:  ref_x_low_reg  <= REG_WDATA_I;
            `AMCD_ADDR_REF_Y_HIGH: ref_y_high_reg <= REG_WDATA_I;
            `AMCD_ADDR_REF_Y_LOW:  ref_y_low_reg  <= REG_WDATA_I;
            `AMCD_ADDR_REF_Z_HIGH: ref_z_high_reg <= REG_WDATA_I;
            `AMCD_ADDR_REF_Z_LOW:  ref_z_low_reg  <= REG_WDATA_I;
            default: ;
         endcase
      end
   end

   // Field assembly
   assign threshold  = {ths_high_reg[`AMCD_THS_HIGH_MSB:0], ths_low_reg};
   assign clear_mode = ths_high_reg[`AMCD_THS_CLRMODE_BIT];
   assign init_x     = {ref_x_high_reg[`AMCD_REF_HIGH_MSB:0], ref_x_low_reg};
   assign init_y     = {ref_y_high_reg[`AMCD_REF_HIGH_MSB:0], ref_y_low_reg};
   assign init_z     = {ref_z_high_reg[`AMCD_REF_HIGH_MSB:0], ref_z_low_reg};

   // Read data registered one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         REG_RDATA_O <= `AMCD_REG_RESET;
      end else if (REG_RD_I) begin
         case (REG_ADDR_I)
            `AMCD_ADDR_THS_HIGH:   REG_RDATA_O <= ths_high_reg;
            `AMCD_ADDR_THS_LOW:    REG_RDATA_O <= ths_low_reg;
            `AMCD_ADDR_DB_COUNT:   REG_RDATA_O <= db_count_reg;
            `AMCD_ADDR_REF_X_HIGH: REG_RDATA_O <= ref_x_high_reg;
            `AMCD_ADDR_REF_X_LOW:  REG_RDATA_O <= ref_x_low_reg;
            `AMCD_ADDR_REF_Y_HIGH: REG_RDATA_O <= ref_y_high_reg;
            `AMCD_ADDR_REF_Y_LOW:  REG_RDATA_O <= ref_y_low_reg;
            `AMCD_ADDR_REF_Z_HIGH: REG_RDATA_O <= ref_z_high_reg;
            `AMCD_ADDR_REF_Z_LOW:  REG_RDATA_O <= ref_z_low_reg;
            default:               REG_RDATA_O <= `AMCD_REG_RESET;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reference point

   amcd_ref_state_t ref_state_reg;
   logic            enable_d_reg;
   amcd_sample_t    ref_x_reg;
   amcd_sample_t    ref_y_reg;
   amcd_sample_t    ref_z_reg;
   amcd_sample_t    smp_x_reg;
   amcd_sample_t    smp_y_reg;
   amcd_sample_t    smp_z_reg;
   logic            trigger;
   logic            enable_rise;

   assign enable_rise = ENABLE_I && !enable_d_reg;

   // Enable edge detect
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         enable_d_reg <= 1'b0;
      end else begin
         enable_d_reg <= ENABLE_I;
      end
   end

   // Sample held for the reference update that follows the compare
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         smp_x_reg <= '0;
         smp_y_reg <= '0;
         smp_z_reg <= '0;
      end else if (SAMPLE_VALID_I) begin
         smp_x_reg <= SAMPLE_X_I;
         smp_y_reg <= SAMPLE_Y_I;
         smp_z_reg <= SAMPLE_Z_I;
      end
   end

   // State: off, waiting for a first sample to capture, or running
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         ref_state_reg <= AMCD_REF_OFF;
      end else begin
         case (ref_state_reg)
            AMCD_REF_OFF: begin
               if (enable_rise) begin
                  ref_state_reg <= INIT_SRC_I ? AMCD_REF_RUN : AMCD_REF_CAPTURE;
               end
            end
            AMCD_REF_CAPTURE: begin
               if (!ENABLE_I) begin
                  ref_state_reg <= AMCD_REF_OFF;
               end else if (SAMPLE_VALID_I) begin
                  ref_state_reg <= AMCD_REF_RUN;
               end
            end
            AMCD_REF_RUN: begin
               if (!ENABLE_I) begin
                  ref_state_reg <= AMCD_REF_OFF;
               end
            end
            default: ref_state_reg <= AMCD_REF_OFF;
         endcase
      end
   end

   // Reference values: loaded at enable, followed live, or moved on a trigger
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         ref_x_reg <= '0;
         ref_y_reg <= '0;
         ref_z_reg <= '0;
      end else if (ref_state_reg == AMCD_REF_OFF && enable_rise && INIT_SRC_I) begin
         ref_x_reg <= init_x; // Programmed values in output counts
         ref_y_reg <= init_y;
         ref_z_reg <= init_z;
      end else if (ref_state_reg == AMCD_REF_CAPTURE && SAMPLE_VALID_I) begin
         ref_x_reg <= SAMPLE_X_I; // First sample after enable
         ref_y_reg <= SAMPLE_Y_I;
         ref_z_reg <= SAMPLE_Z_I;
      end else if (ref_state_reg == AMCD_REF_RUN && INIT_SRC_I && REF_HOLD_I) begin
         ref_x_reg <= init_x; // Host writes act at once
         ref_y_reg <= init_y;
         ref_z_reg <= init_z;
      end else if (trigger && !REF_HOLD_I) begin
         ref_x_reg <= smp_x_reg; // Reference follows the triggering sample
         ref_y_reg <= smp_y_reg;
         ref_z_reg <= smp_z_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Distance compare

   logic cmp_done;
   logic cmp_above;
   logic cmp_start;

   // Compare only once a reference exists
   assign cmp_start = SAMPLE_VALID_I && ref_state_reg == AMCD_REF_RUN;

   // Threshold taken in raw output counts, so it scales with range
   amcd_distance #(
      .DATA_W (DATA_W),
      .THS_W  (THS_W)
   ) u_distance (
      .MCLK_I    (MCLK_I),
      .SYS_RST_I (SYS_RST_I),
      .START_I   (cmp_start),
      .X_I       (SAMPLE_X_I),
      .Y_I       (SAMPLE_Y_I),
      .Z_I       (SAMPLE_Z_I),
      .REF_X_I   (ref_x_reg),
      .REF_Y_I   (ref_y_reg),
      .REF_Z_I   (ref_z_reg),
      .THS_I     (threshold),
      .DONE_O    (cmp_done),
      .ABOVE_O   (cmp_above)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Debounce and event flag

   logic [CNT_W-1:0] db_cnt_reg;
   logic [CNT_W-1:0] db_cnt_next;
   logic             phase_reg;
   logic             step;

   // In hybrid mode only every other result advances the counter
   assign step = cmp_done && (!HYBRID_I || phase_reg);

   // Hybrid phase toggles per result
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I || !ENABLE_I) begin
         phase_reg <= 1'b0;
      end else if (cmp_done) begin
         phase_reg <= !phase_reg;
      end
   end

   // Next count: up while above, down or cleared while below, saturating
   always_comb begin
      db_cnt_next = db_cnt_reg;
      if (cmp_above) begin
         if (db_cnt_reg < db_count_reg) begin
            db_cnt_next = db_cnt_reg + CNT_W'(1);  // One step per sample, per two samples in hybrid mode
         end
      end else if (clear_mode) begin
         db_cnt_next = '0;
      end else if (db_cnt_reg != '0) begin
         db_cnt_next = db_cnt_reg - CNT_W'(1);
      end
   end

   // Debounce counter
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I || !ENABLE_I) begin
         db_cnt_reg <= '0;
      end else if (step) begin
         db_cnt_reg <= db_cnt_next;
      end
   end

   // Condition true once above with the count already used up
   assign trigger = step && cmp_above && db_cnt_reg >= db_count_reg && !ACTIVE_O;

   // Real-time condition: cleared once the counter drains while below
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I || !ENABLE_I) begin
         ACTIVE_O <= 1'b0;
      end else if (trigger) begin
         ACTIVE_O <= 1'b1;
      end else if (step && !cmp_above && db_cnt_next == '0) begin
         ACTIVE_O <= 1'b0;
      end
   end

   // Event flag; a trigger in the clearing cycle wins over the read.
   // Unlatched, it drops with the enable in the same edge as the condition.
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         EVENT_O <= 1'b0;
      end else if (!LATCH_EN_I) begin
         EVENT_O <= ENABLE_I && (trigger || (ACTIVE_O && !(step && !cmp_above && db_cnt_next == '0)));
      end else if (trigger) begin
         EVENT_O <= 1'b1;
      end else if (SRC_READ_I) begin
         EVENT_O <= 1'b0;
      end
   end

endmodule

// >>> core/amcd_defines.svh
/*
 * Register offsets, field positions, reset values and widths of the
 * accelerometer magnitude change detector.
 * Assumes it is included by bare name from files under core/.
 */
`ifndef AMCD_DEFINES_SVH
`define AMCD_DEFINES_SVH

// Byte register offsets
`define AMCD_ADDR_THS_HIGH     8'h60
`define AMCD_ADDR_THS_LOW      8'h61
`define AMCD_ADDR_DB_COUNT     8'h62
`define AMCD_ADDR_REF_X_HIGH   8'h63
`define AMCD_ADDR_REF_X_LOW    8'h64
`define AMCD_ADDR_REF_Y_HIGH   8'h65
`define AMCD_ADDR_REF_Y_LOW    8'h66
`define AMCD_ADDR_REF_Z_HIGH   8'h67
`define AMCD_ADDR_REF_Z_LOW    8'h68

// Common reset value of every byte register
`define AMCD_REG_RESET         8'h00

// Field positions in the high threshold byte
`define AMCD_THS_CLRMODE_BIT   7
`define AMCD_THS_HIGH_MSB      4
// Field positions in the high reference bytes
`define AMCD_REF_HIGH_MSB      5

// Documented widths
`define AMCD_THS_WIDTH         13
`define AMCD_CNT_WIDTH         8
`define AMCD_DATA_WIDTH        14

`endif

// >>> core/amcd_distance.sv
/*
 * Squared distance between a sample and the reference point, compared
 * against the squared threshold; result registered one cycle after start.
 * Assumes inputs stand during the cycle in which START_I is high.
 */
`timescale 1ns/1ps
`include "amcd_defines.svh"

module amcd_distance #(
   parameter int DATA_W = `AMCD_DATA_WIDTH,
   parameter int THS_W  = `AMCD_THS_WIDTH
) (
   input  wire logic                     MCLK_I,
   input  wire logic                     SYS_RST_I,
   input  wire logic                     START_I,
   input  wire logic signed [DATA_W-1:0] X_I,
   input  wire logic signed [DATA_W-1:0] Y_I,
   input  wire logic signed [DATA_W-1:0] Z_I,
   input  wire logic signed [DATA_W-1:0] REF_X_I,
   input  wire logic signed [DATA_W-1:0] REF_Y_I,
   input  wire logic signed [DATA_W-1:0] REF_Z_I,
   input  wire logic        [THS_W-1:0]  THS_I,
   output logic                          DONE_O,
   output logic                          ABOVE_O
);
   import amcd_pkg::*;

   localparam int SQ_W  = 2 * (DATA_W + 1);
   localparam int SUM_W = SQ_W + 2;

   // Square of one axis difference; the difference needs one extra bit
   function automatic logic [SQ_W-1:0] axis_sq(input logic signed [DATA_W-1:0] a,
                                               input logic signed [DATA_W-1:0] b);
      logic signed [DATA_W:0] d;
      logic        [DATA_W:0] m;
      d = {a[DATA_W-1], a} - {b[DATA_W-1], b};
      m = d[DATA_W] ? (DATA_W+1)'(-d) : d;
      axis_sq = SQ_W'(m) * SQ_W'(m);
   endfunction

   logic [SUM_W-1:0] sum_sq;
   logic [SUM_W-1:0] ths_sq;

   // Squares avoid a square root and give the same ordering
   assign sum_sq = SUM_W'(axis_sq(X_I, REF_X_I)) + SUM_W'(axis_sq(Y_I, REF_Y_I))
                 + SUM_W'(axis_sq(Z_I, REF_Z_I));
   assign ths_sq = SUM_W'(THS_I) * SUM_W'(THS_I);

   // Registered result, one cycle after start
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         DONE_O  <= 1'b0;
         ABOVE_O <= 1'b0;
      end else begin
         DONE_O <= START_I;
         if (START_I) begin
            ABOVE_O <= sum_sq > ths_sq; // Strictly greater than threshold
         end
      end
   end

endmodule

// >>> core/amcd_pkg.sv
/*
 * Types of the accelerometer magnitude change detector.
 * Assumes amcd_defines.svh is compiled alongside.
 */
package amcd_pkg;

   // Reference handling state
   typedef enum logic [1:0] {
      AMCD_REF_OFF     = 2'b00,
      AMCD_REF_CAPTURE = 2'b01,
      AMCD_REF_RUN     = 2'b10
   } amcd_ref_state_t;

   // One axis sample, two's complement
   typedef logic signed [13:0] amcd_sample_t;

endpackage

// >>> sim/amcd_core_assertions.sv
/*
 * Concurrent checks on the ports of the magnitude change detector.
 * Assumes one clock domain and the synchronous active-high reset.
 */
`timescale 1ns/1ps
module amcd_checker (
   input wire logic       MCLK_I,
   input wire logic       SYS_RST_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic       REG_WR_I,
   input wire logic       REG_RD_I,
   input wire logic       ENABLE_I,
   input wire logic       LATCH_EN_I,
   input wire logic       SRC_READ_I,
   input wire logic       SAMPLE_VALID_I,
   input wire logic [7:0] REG_RDATA_O,
   input wire logic       EVENT_O,
   input wire logic       ACTIVE_O
);
   logic [7:0] cnt_shadow_reg;

   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);

   ////////////////////////////////////////////////////////////////////////
   // Shadow of the debounce count byte, so read data has a reference
   always_ff @(posedge MCLK_I) begin
      if (SYS_RST_I) begin
         cnt_shadow_reg <= 8'h00;
      end else if (REG_WR_I && REG_ADDR_I == 8'h62) begin
         cnt_shadow_reg <= REG_WDATA_I;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Latched flag with nothing that may clear it
   sequence s_latched_idle;
      LATCH_EN_I && ENABLE_I && EVENT_O && !SRC_READ_I;
   endsequence
   // Latch off long enough for the flag to settle
   sequence s_unlatched;
      !LATCH_EN_I [*2];
   endsequence

   a_reset_quiet: assert property (@(posedge MCLK_I) disable iff (1'b0)
      SYS_RST_I |=> !EVENT_O && !ACTIVE_O && REG_RDATA_O == 8'h00) else $error("outputs not quiet after reset");
   a_count_readback: assert property (REG_RD_I && !REG_WR_I && REG_ADDR_I == 8'h62
      |=> REG_RDATA_O == $past(cnt_shadow_reg)) else $error("count byte read back wrong");
   a_unmapped_zero: assert property (REG_RD_I && (REG_ADDR_I < 8'h60 || REG_ADDR_I > 8'h68)
      |=> REG_RDATA_O == 8'h00) else $error("unmapped read not zero");
   a_rdata_stands: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
      else $error("read data moved without a read");
   a_rise_from_sample: assert property ($rose(ACTIVE_O) |-> $past(SAMPLE_VALID_I, 2))
      else $error("condition rose without a sample");
   a_fall_cause: assert property ($fell(ACTIVE_O)
      |-> $past(SAMPLE_VALID_I, 2) || !$past(ENABLE_I) || !$past(ENABLE_I, 2)) else $error("condition fell without cause");
   a_disable_clears: assert property (!ENABLE_I [*3] |-> !ACTIVE_O)
      else $error("condition held while disabled");
   a_latch_holds: assert property (s_latched_idle |=> EVENT_O)
      else $error("latched flag dropped without source read");
   a_unlatched_follow: assert property (s_unlatched |-> EVENT_O == ACTIVE_O)
      else $error("unlatched flag differs from condition");
endmodule

bind amcd_core amcd_checker i_chk (.*);

// >>> sim/amcd_sample_src.sv
/*
 * Model of the sample pipeline: one axis triple per valid pulse.
 * Assumes the caller waits for each send to return before the next.
 */
`timescale 1ns/1ps
module amcd_sample_src (
   input  wire logic             MCLK_I,
   output logic                  VALID_O,
   output amcd_pkg::amcd_sample_t X_O,
   output amcd_pkg::amcd_sample_t Y_O,
   output amcd_pkg::amcd_sample_t Z_O
);
   import amcd_pkg::*;

   initial begin
      VALID_O = 1'b0;
      X_O = '0;
      Y_O = '0;
      Z_O = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Data stands only with the pulse; afterwards the lines carry the
   // inverse, so a late capture fails instead of passing by luck
   task automatic send(input amcd_sample_t x, input amcd_sample_t y, input amcd_sample_t z);
      @(posedge MCLK_I);
      VALID_O <= 1'b1;
      X_O <= x;
      Y_O <= y;
      Z_O <= z;
      @(posedge MCLK_I);
      VALID_O <= 1'b0;
      X_O <= ~x;
      Y_O <= ~y;
      Z_O <= ~z;
      repeat (3) @(posedge MCLK_I); // Spacing above the two-cycle minimum
   endtask
endmodule

// >>> sim/tb_amcd_core.sv
/*
 * Self-checking bench for the magnitude change detector.
 * Assumes the sample model and the checker are compiled alongside.
 */
`timescale 1ns/1ps
module tb_amcd_core;
   import amcd_pkg::*;
   logic         MCLK_I = 1'b0;
   logic         SYS_RST_I = 1'b1;
   logic [7:0]   REG_ADDR_I = 8'h00;
   logic [7:0]   REG_WDATA_I = 8'h00;
   logic         REG_WR_I = 1'b0;
   logic         REG_RD_I = 1'b0;
   logic         SRC_READ_I = 1'b0;
   logic         ENABLE_I = 1'b0;
   logic         LATCH_EN_I = 1'b0;
   logic         INIT_SRC_I = 1'b0;
   logic         REF_HOLD_I = 1'b0;
   logic         HYBRID_I = 1'b0;
   logic         SAMPLE_VALID_I;
   amcd_sample_t SAMPLE_X_I;
   amcd_sample_t SAMPLE_Y_I;
   amcd_sample_t SAMPLE_Z_I;
   logic [7:0]   REG_RDATA_O;
   logic         EVENT_O;
   logic         ACTIVE_O;
   int           mismatches = 0;
   int           check_count = 0;
   int           cycles = 0;

   amcd_core i_dut (.*);
   amcd_sample_src i_src (.MCLK_I(MCLK_I), .VALID_O(SAMPLE_VALID_I), .X_O(SAMPLE_X_I),
      .Y_O(SAMPLE_Y_I), .Z_O(SAMPLE_Z_I));

   initial begin
      forever #20 MCLK_I = ~MCLK_I;
   end

   ////////////////////////////////////////////////////////////////////////
   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge MCLK_I) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         test_done();
      end
   end

   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      check_count++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge MCLK_I);
      REG_ADDR_I <= a;
      REG_WDATA_I <= d;
      REG_WR_I <= 1'b1;
      @(posedge MCLK_I);
      REG_WR_I <= 1'b0;
   endtask

   // Data is looked at one cycle after the strobe edge, where it stands
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge MCLK_I);
      REG_ADDR_I <= a;
      REG_RD_I <= 1'b1;
      @(posedge MCLK_I);
      REG_RD_I <= 1'b0;
      #1 chk(REG_RDATA_O, e);
   endtask

   // Order: enable, latch, init source, hold, hybrid
   task automatic cfg(input logic [4:0] v);
      @(posedge MCLK_I);
      {ENABLE_I, LATCH_EN_I, INIT_SRC_I, REF_HOLD_I, HYBRID_I} <= v;
      repeat (2) @(posedge MCLK_I);
   endtask

   task automatic smp(input amcd_sample_t x, input amcd_sample_t y, input amcd_sample_t z, input logic e);
      i_src.send(x, y, z);
      #1 chk({7'h00, ACTIVE_O}, {7'h00, e});
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge MCLK_I);
      SYS_RST_I <= 1'b0;
      for (logic [7:0] a = 8'h5f; a <= 8'h69; a++) rd(a, 8'h00);
      for (logic [7:0] a = 8'h60; a <= 8'h68; a++) wr(a, a ^ 8'h5c);
      for (logic [7:0] a = 8'h60; a <= 8'h68; a++) rd(a, a ^ 8'h5c);
      wr(8'h69, 8'h5a);
      rd(8'h69, 8'h00);
      $display("test registers finished");
      // Threshold 10, count 2, clear mode 0, programmed reference at origin
      for (logic [7:0] a = 8'h63; a <= 8'h68; a++) wr(a, 8'h00);
      wr(8'h60, 8'h00);
      wr(8'h61, 8'h0a);
      wr(8'h62, 8'h02);
      cfg(5'b10110);
      smp(10, 0, 0, 1'b0);
      smp(6, 8, 1, 1'b0);
      smp(11, 0, 0, 1'b0);
      smp(0, 0, -11, 1'b1);
      smp(0, 0, 0, 1'b1);
      smp(11, 0, 0, 1'b1);
      smp(11, 0, 0, 1'b1);
      smp(0, 0, 0, 1'b1);
      smp(0, 0, 0, 1'b0);
      smp(0, 0, 0, 1'b0);
      smp(11, 0, 0, 1'b0);
      smp(11, 0, 0, 1'b0);
      smp(11, 0, 0, 1'b1);
      $display("test decrement finished");
      // Clear mode 1 drops the condition on the first low result
      cfg(5'b00000);
      wr(8'h60, 8'h80);
      cfg(5'b10110);
      repeat (2) smp(11, 0, 0, 1'b0);
      smp(11, 0, 0, 1'b1);
      smp(0, 0, 0, 1'b0);
      $display("test clear finished");
      // Latched flag survives a low result until the source read
      cfg(5'b00000);
      wr(8'h62, 8'h00);
      cfg(5'b11110);
      smp(11, 0, 0, 1'b1);
      smp(0, 0, 0, 1'b0);
      chk({7'h00, EVENT_O}, 8'h01);
      @(posedge MCLK_I);
      SRC_READ_I <= 1'b1;
      @(posedge MCLK_I);
      SRC_READ_I <= 1'b0;
      repeat (2) @(posedge MCLK_I);
      #1 chk({7'h00, EVENT_O}, 8'h00);
      $display("test latch finished");
      // Negative programmed reference, then a live update with hold set
      cfg(5'b00000);
      wr(8'h63, 8'h3f);
      wr(8'h64, 8'h9c);
      cfg(5'b10110);
      smp(-100, 0, 0, 1'b0);
      smp(-111, 0, 0, 1'b1);
      wr(8'h64, 8'h91);
      smp(-111, 0, 0, 1'b0);
      $display("test reference finished");
      // Captured reference ignores the programmed one, moves on trigger
      cfg(5'b00000);
      cfg(5'b10000);
      smp(500, 500, 500, 1'b0);
      smp(505, 500, 500, 1'b0);
      smp(500, 500, 489, 1'b1);
      smp(500, 500, 489, 1'b0);
      $display("test capture finished");
      // Hybrid mode needs more samples for the same count
      cfg(5'b00000);
      wr(8'h62, 8'h02);
      cfg(5'b10111);
      repeat (3) smp(0, 0, 0, 1'b0);
      repeat (2) i_src.send(0, 0, 0);
      smp(0, 0, 0, 1'b1);
      $display("test hybrid finished");
      test_done();
   end
endmodule
